// File: sas_embedder_shuffler.sv
// Notes on behaviour
// - Twelve channels, each processed fully independently.
// - Only SD and HD video passes; others dropped.
// - Video path always on, about four microseconds.
// - Output words regenerated from local flip-flops.
// - Each channel picks primary or redundant input.
// - TDM stream splits into 96 pairs, eight per channel.
// - Embedder needs TDM timing; shuffler does not.
// - Embedder replaces embedded audio with TDM audio.
// - Shuffler rearranges embedded audio inside one channel.
// - Variant input high means shuffler, low embedder.
// - Default mode input high passes, low mutes.
// - Pass mode forwards audio of uncontrolled outputs.
// - Mute mode silences audio of uncontrolled outputs.
// - Pass or mute applies to all twelve outputs.
// - One lock indicator per channel, lit when locked.
// - Separate configured indicators for audio and channels.
// - Alarm indicator lights on any board fault.
// - Comms indicator lights while card is addressed.
// - Power good only while all supplies healthy.
// - Reset button cold-resets all card logic.
`timescale 1ns/1ns
`default_nettype none

module sas_embedder_shuffler #(
    parameter int LOCK_WORDS = sas_pkg::LOCK_WORDS_DEF,
    parameter int LOSS_CYC = sas_pkg::LOSS_CYC_DEF,
    parameter int COMMS_HOLD = sas_pkg::COMMS_HOLD_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Card switches and supply monitors, all asynchronous pins.
    input wire logic coldResetButton,
    input wire logic variantSelectIn,
    input wire logic defaultAudioModeIn,
    input wire logic [sas_pkg::SUPPLY_N-1:0] supplyOk,
    // Multiplexed audio stream pins.
    input wire logic tdmClk,
    input wire logic tdmData,
    input wire logic tdmSync,
    // Deserialized video from the two crosspoints, and the output words.
    input wire sas_pkg::sas_vid_t vidPri [sas_pkg::NUM_CH],
    input wire sas_pkg::sas_vid_t vidRed [sas_pkg::NUM_CH],
    output var sas_pkg::sas_vid_t vidOut [sas_pkg::NUM_CH],
    // Register port.
    input wire logic [sas_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Front-edge indicators.
    output var sas_pkg::sas_leds_t leds
);
    import sas_pkg::*;

    localparam int DLY_DEPTH = VID_DELAY_CYC - 1;
    localparam int PTR_W = $clog2(DLY_DEPTH);
    localparam int PIN_N = 5 + SUPPLY_N;

    // ======================================================================
    // Parameter checks.
    // ======================================================================
    if (LOCK_WORDS < 1 || LOCK_WORDS > 255) begin : gLockChk
        $error("LOCK_WORDS must lie in 1..255");
    end
    if (LOSS_CYC < 2 || LOSS_CYC > 255) begin : gLossChk
        $error("LOSS_CYC must lie in 2..255");
    end
    if (COMMS_HOLD < 1 || COMMS_HOLD >= (1 << 20)) begin : gCommsChk
        $error("COMMS_HOLD must lie in 1..2**20-1");
    end
    if (NUM_CH * PAIRS_PER_CH != TDM_PAIRS || DLY_DEPTH < 2) begin : gMapChk
        $error("Channel, pair or delay sizes are inconsistent");
    end

    // Index of a TDM slot: channel block, pair within it, then left or right.
    function automatic logic [SLOT_W-1:0] tdmIndex(input int ch, input logic [PAIR_W-1:0] src,
                                                   input logic right);
        int idx;
        idx = ((ch * PAIRS_PER_CH + int'(src)) * 2) + int'(right);
        return idx[SLOT_W-1:0];
    endfunction

    // True for the only two video rates the path can carry.
    function automatic logic rateSupported(input sas_vid_t w);
        return w.valid && (w.rate == SAS_RATE_SD || w.rate == SAS_RATE_HD);
    endfunction

    // ======================================================================
    // Reset button and pin synchronisers.
    // ======================================================================
    logic btnMeta_r;
    logic btnSync_r;
    logic rst;

    // The button stage is cleared by the board reset only, so that it can
    // itself hold the rest of the logic in reset.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            btnMeta_r <= 1'b0;
            btnSync_r <= 1'b0;
        end else begin
            btnMeta_r <= coldResetButton;
            btnSync_r <= btnMeta_r;
        end
    end

    assign rst = !reset_n || btnSync_r;

    logic [PIN_N-1:0] pinMeta_r;
    logic [PIN_N-1:0] pinSync_r;
    logic tdmClkDly_r;
    logic isShuffler;
    logic passThrough;
    logic suppliesGood;
    logic tdmClkS;
    logic tdmDataS;
    logic tdmSyncS;
    logic tdmRise;

    // Every pin passes two flops before anything looks at it.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
            tdmClkDly_r <= 1'b0;
        end else begin
            pinMeta_r <= {variantSelectIn, defaultAudioModeIn, supplyOk, tdmClk, tdmData,
                          tdmSync};
            pinSync_r <= pinMeta_r;
            tdmClkDly_r <= tdmClkS;
        end
    end

    assign isShuffler = pinSync_r[PIN_N-1];
    assign passThrough = pinSync_r[PIN_N-2];
    assign suppliesGood = &pinSync_r[3 +: SUPPLY_N];
    assign tdmClkS = pinSync_r[2];
    assign tdmDataS = pinSync_r[1];
    assign tdmSyncS = pinSync_r[0];
    assign tdmRise = tdmClkS && !tdmClkDly_r;

    // ======================================================================
    // Multiplexed audio receiver.
    // ======================================================================
    sas_tdm_state_t tdmState_r;
    logic [3:0] bitCnt_r;
    logic [SLOT_W-1:0] slot_r;
    logic [AUD_BITS-1:0] shift_r;
    logic tdmLocked_r;
    logic slotDone;
    logic [AUD_BITS-1:0] tdmSample [TDM_SLOTS];

    assign slotDone = tdmRise && !tdmSyncS && tdmState_r == SAS_TDM_RUN &&
                      bitCnt_r == 4'(AUD_BITS - 1);

    // Frames open on the sync bit, which is also the first bit (bit 9) of slot 0. Losing the
    // sync at the next frame start drops lock; that check waits on a clock edge,
    // so lock stays set while the link clock is stopped.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tdmState_r <= SAS_TDM_HUNT;
            bitCnt_r <= '0;
            slot_r <= '0;
            shift_r <= '0;
            tdmLocked_r <= 1'b0;
        end else if (tdmRise) begin
            if (tdmSyncS) begin
                tdmState_r <= SAS_TDM_RUN;
                tdmLocked_r <= 1'b1;
                bitCnt_r <= 4'd1;
                slot_r <= '0;
                shift_r <= {{(AUD_BITS - 1){1'b0}}, tdmDataS};
            end else begin
                case (tdmState_r)
                    SAS_TDM_RUN: begin
                        shift_r <= {shift_r[AUD_BITS-2:0], tdmDataS};
                        if (slotDone) begin
                            bitCnt_r <= '0;
                            if (slot_r == SLOT_W'(TDM_SLOTS - 1)) begin
                                tdmState_r <= SAS_TDM_WAIT;
                            end else begin
                                slot_r <= slot_r + 1'b1;
                            end
                        end else begin
                            bitCnt_r <= bitCnt_r + 1'b1;
                        end
                    end
                    SAS_TDM_WAIT: begin
                        tdmState_r <= SAS_TDM_HUNT;
                        tdmLocked_r <= 1'b0;
                    end
                    default: begin
                        tdmState_r <= SAS_TDM_HUNT;
                    end
                endcase
            end
        end
    end

    // One sample per slot, 192 slots as 96 pairs.
    always_ff @(posedge mclk) begin
        if (slotDone) begin
            tdmSample[slot_r] <= {shift_r[AUD_BITS-2:0], tdmDataS};
        end
    end

    // ======================================================================
    // Register port.
    // ======================================================================
    logic [31:0] ctrl_r;
    logic [31:0] route_r [NUM_CH];
    logic [31:0] regRdata_r;
    logic [19:0] commsCnt_r;
    logic [NUM_CH-1:0] chanLock;
    logic [NUM_CH-1:0] badRate_r;
    logic routeHit;
    logic [3:0] routeIdx;

    assign routeHit = regAddr >= REG_ROUTE_BASE && regAddr <= REG_ROUTE_LAST &&
                      regAddr[1:0] == 2'b00;
    assign routeIdx = 4'((regAddr - REG_ROUTE_BASE) >> 2);

    // Route nibbles clear to zero: every output starts uncontrolled.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                route_r[c] <= ROUTE_RESET;
            end
        end else if (regWr) begin
            if (regAddr == REG_CTRL) begin
                ctrl_r <= regWdata;
            end else if (routeHit) begin
                route_r[routeIdx] <= regWdata;
            end
        end
    end

    // Read data stands for the one cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata_r <= READ_UNMAPPED;
        end else if (regRd) begin
            if (regAddr == REG_CTRL) begin
                regRdata_r <= ctrl_r;
            end else if (regAddr == REG_STATUS) begin
                regRdata_r <= READ_UNMAPPED;
                regRdata_r[ST_LOCK_LSB +: NUM_CH] <= chanLock;
                regRdata_r[ST_TDMLOCK_BIT] <= tdmLocked_r;
                regRdata_r[ST_VARIANT_BIT] <= isShuffler;
                regRdata_r[ST_PASSTHRU_BIT] <= passThrough;
                regRdata_r[ST_SUPPLY_BIT] <= suppliesGood;
                regRdata_r[ST_BADRATE_LSB +: NUM_CH] <= badRate_r;
            end else if (routeHit) begin
                regRdata_r <= route_r[routeIdx];
            end else begin
                regRdata_r <= READ_UNMAPPED;
            end
        end else begin
            regRdata_r <= READ_UNMAPPED;
        end
    end

    assign regRdata = regRdata_r;

    // Any access retriggers the stretch, so a human can see short bursts.
    always_ff @(posedge mclk) begin
        if (rst) begin
            commsCnt_r <= '0;
        end else if (regWr || regRd) begin
            commsCnt_r <= 20'(COMMS_HOLD);
        end else if (commsCnt_r != '0) begin
            commsCnt_r <= commsCnt_r - 1'b1;
        end
    end

    // ======================================================================
    // Per-channel audio processing.
    // ======================================================================
    sas_vid_t selW [NUM_CH];
    logic [NUM_CH-1:0] supp;
    sas_vid_t procNxt [NUM_CH];
    logic [AUD_BITS-1:0] embStore [NUM_CH][2*PAIRS_PER_CH];

    // Each channel touches only its own inputs, table and store.
    always_comb begin
        logic [ROUTE_ENTRY_W-1:0] ent;
        logic [PAIR_W-1:0] src;
        logic ctl;
        ent = '0;
        src = '0;
        ctl = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            selW[c] = ctrl_r[CTRL_SRCSEL_LSB + c] ? vidRed[c] : vidPri[c];
            supp[c] = rateSupported(selW[c]);
            procNxt[c] = selW[c];
            if (!supp[c]) begin
                procNxt[c] = '0;
            end else if (selW[c].anc) begin
                ent = route_r[c][ROUTE_ENTRY_W * int'(selW[c].pair) +: ROUTE_ENTRY_W];
                src = ent[PAIR_W-1:0];
                // Without TDM timing the embedder treats its pairs as uncontrolled.
                ctl = ent[ROUTE_EN_BIT] && (isShuffler || tdmLocked_r);
                if (ctl && isShuffler) begin
                    procNxt[c].data = embStore[c][{src, selW[c].right}];
                end else if (ctl) begin
                    procNxt[c].data = tdmSample[tdmIndex(c, src, selW[c].right)];
                end else if (!passThrough) begin
                    // Only the sample is cleared; anc, pair and side stay.
                    procNxt[c].data = '0;
                end
                // Otherwise the arriving sample stands unchanged.
            end
        end
    end

    // Latest raw sample of each embedded pair, the shuffler's source.
    always_ff @(posedge mclk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (supp[c] && selW[c].anc) begin
                embStore[c][{selW[c].pair, selW[c].right}] <= selW[c].data;
            end
        end
    end

    // ======================================================================
    // Fixed video delay and output regeneration.
    // ======================================================================
    sas_vid_t vidDly [NUM_CH][DLY_DEPTH];
    logic [PTR_W-1:0] dlyPtr_r;
    logic primed_r;

    // The ring is never bypassed, so delay does not depend on audio mode.
    always_ff @(posedge mclk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            vidDly[c][dlyPtr_r] <= procNxt[c];
        end
    end

    // Until the ring has been filled once its contents are unknown, so the
    // output holds idle words instead.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dlyPtr_r <= '0;
            primed_r <= 1'b0;
        end else if (dlyPtr_r == PTR_W'(DLY_DEPTH - 1)) begin
            dlyPtr_r <= '0;
            primed_r <= 1'b1;
        end else begin
            dlyPtr_r <= dlyPtr_r + 1'b1;
        end
    end

    // Output words come straight from flops on the local clock.
    always_ff @(posedge mclk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst || !primed_r) begin
                vidOut[c] <= '0;
            end else begin
                vidOut[c] <= vidDly[c][dlyPtr_r];
            end
        end
    end

    // ======================================================================
    // Lock detection and rate fault per channel.
    // ======================================================================
    logic [7:0] runCnt_r [NUM_CH];
    logic [7:0] missCnt_r [NUM_CH];

    // Lock needs LOCK_WORDS good words; LOSS_CYC idle cycles in a row drop it.
    always_ff @(posedge mclk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst) begin
                runCnt_r[c] <= '0;
                missCnt_r[c] <= '0;
                badRate_r[c] <= 1'b0;
            end else begin
                if (supp[c]) begin
                    missCnt_r[c] <= '0;
                    badRate_r[c] <= 1'b0;
                    if (runCnt_r[c] != 8'(LOCK_WORDS)) begin
                        runCnt_r[c] <= runCnt_r[c] + 1'b1;
                    end
                end else if (missCnt_r[c] == 8'(LOSS_CYC - 1)) begin
                    runCnt_r[c] <= '0;
                    missCnt_r[c] <= '0;
                end else begin
                    missCnt_r[c] <= missCnt_r[c] + 1'b1;
                end
                if (selW[c].valid && !supp[c]) begin
                    badRate_r[c] <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chanLock[c] = runCnt_r[c] == 8'(LOCK_WORDS);
        end
    end

    // ======================================================================
    // Front-edge indicators.
    // ======================================================================
    always_ff @(posedge mclk) begin
        if (rst) begin
            leds <= '0;
        end else begin
            leds.chanLock <= chanLock;
            leds.audioProcCfg <= ctrl_r[CTRL_AUDCFG_BIT];
            leds.chanLogicCfg <= ctrl_r[CTRL_CHCFG_BIT];
            leds.suppliesGood <= suppliesGood;
            leds.faultAlarm <= !suppliesGood || ctrl_r[CTRL_FAULT_BIT] || (|badRate_r);
            leds.controlComms <= commsCnt_r != '0;
        end
    end

endmodule

`default_nettype wire

// File: sas_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants and types for the SDI audio embedder and shuffler.
// ==========================================================================
package sas_pkg;

    // ======================================================================
    // Sizes of the card.
    // ======================================================================
    localparam int NUM_CH = 12;
    localparam int PAIRS_PER_CH = 8;
    localparam int TDM_SLOTS = 192;
    localparam int TDM_PAIRS = 96;
    localparam int AUD_BITS = 10;
    localparam int SUPPLY_N = 4;
    localparam int PAIR_W = 3;
    localparam int SLOT_W = 8;

    // ======================================================================
    // Timing, expressed in their own units and converted to mclk cycles.
    // ======================================================================
    localparam int MCLK_HZ = 10_000_000;
    localparam int VID_DELAY_NS = 4000;
    localparam int VID_DELAY_CYC = (VID_DELAY_NS * (MCLK_HZ / 1_000_000)) / 1000;
    localparam int COMMS_HOLD_MS = 50;
    localparam int COMMS_HOLD_CYC = COMMS_HOLD_MS * (MCLK_HZ / 1000);
    localparam int LOCK_WORDS_DEF = 16;
    localparam int LOSS_CYC_DEF = 64;

    // ======================================================================
    // Register map, byte addresses on the register port's 8-bit address.
    // ======================================================================
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ROUTE_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] REG_ROUTE_LAST = 8'h6C;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // Control fields.
    localparam int CTRL_AUDCFG_BIT = 0;
    localparam int CTRL_CHCFG_BIT = 1;
    localparam int CTRL_FAULT_BIT = 2;
    localparam int CTRL_SRCSEL_LSB = 16;

    // Status fields.
    localparam int ST_LOCK_LSB = 0;
    localparam int ST_TDMLOCK_BIT = 12;
    localparam int ST_VARIANT_BIT = 13;
    localparam int ST_PASSTHRU_BIT = 14;
    localparam int ST_SUPPLY_BIT = 15;
    localparam int ST_BADRATE_LSB = 16;

    // Route entry: one nibble per output pair.
    localparam int ROUTE_ENTRY_W = 4;
    localparam int ROUTE_EN_BIT = 3;

    // ======================================================================
    // Types.
    // ======================================================================
    typedef enum logic [1:0] {
        SAS_RATE_SD,
        SAS_RATE_HD,
        SAS_RATE_3G,
        SAS_RATE_OTHER
    } sas_rate_t;

    typedef struct packed {
        logic valid;
        logic anc;
        logic right;
        logic [PAIR_W-1:0] pair;
        sas_rate_t rate;
        logic [AUD_BITS-1:0] data;
    } sas_vid_t;

    typedef struct packed {
        logic [NUM_CH-1:0] chanLock;
        logic audioProcCfg;
        logic chanLogicCfg;
        logic suppliesGood;
        logic faultAlarm;
        logic controlComms;
    } sas_leds_t;

    typedef enum {
        SAS_TDM_HUNT,
        SAS_TDM_RUN,
        SAS_TDM_WAIT
    } sas_tdm_state_t;

endpackage

`default_nettype wire

// File: sas_embedder_shuffler_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Port checks: reset, supplies, comms, video delay, lock.
// ====
module sas_embedder_shuffler_asserts #(
    parameter int LOSS_CYC = sas_pkg::LOSS_CYC_DEF
) (
    // Clock, reset and pins.
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic coldResetButton,
    input wire logic [sas_pkg::SUPPLY_N-1:0] supplyOk,
    // Register port.
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Video and indicators.
    input wire sas_pkg::sas_vid_t vidPri [sas_pkg::NUM_CH],
    input wire sas_pkg::sas_vid_t vidOut [sas_pkg::NUM_CH],
    input wire sas_pkg::sas_leds_t leds
);
    import sas_pkg::*;
    int idleCnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || coldResetButton);
    // Idle cycles on channel 0; saturates so it never wraps.
    always_ff @(posedge mclk) begin
        if (!reset_n || vidPri[0].valid) begin
            idleCnt <= 0;
        end else if (idleCnt < LOSS_CYC + 8) begin
            idleCnt <= idleCnt + 1;
        end
    end
    sequence pwrBad_s;
        !(&supplyOk) [*8];
    endsequence
    sequence pwrOk_s;
        (&supplyOk) [*8];
    endsequence
    rst_quiet_a: assert property (
        disable iff (1'b0) !reset_n |=> leds == '0 && regRdata == '0)
        else $error("outputs not cleared by reset");
    pwr_bad_a: assert property (pwrBad_s |=> !leds.suppliesGood)
        else $error("power good lit with a supply down");
    pwr_good_a: assert property (pwrOk_s |=> leds.suppliesGood)
        else $error("power good dark with supplies healthy");
    fault_pwr_a: assert property (pwrBad_s |=> leds.faultAlarm)
        else $error("alarm dark with a supply down");
    comms_on_a: assert property ((regWr || regRd) |-> ##[1:2] leds.controlComms)
        else $error("comms dark after an access");
    vid_delay_a: assert property (vidOut[0].valid |-> $past(vidPri[0].valid, 40))
        else $error("output word without input forty cycles earlier");
    vid_frame_a: assert property (
        vidOut[0].valid |-> vidOut[0].pair == $past(vidPri[0].pair, 40))
        else $error("audio packet pair field altered");
    vid_rate_a: assert property (
        $past(vidPri[11].rate, 40) == SAS_RATE_3G |-> vidOut[11] == '0)
        else $error("unsupported rate passed");
    lock_loss_a: assert property (idleCnt == LOSS_CYC + 3 |-> !leds.chanLock[0])
        else $error("lock held without video");
endmodule
`default_nettype wire

// File: sas_tdm_model.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Audio stream source: one frame, then the clock is parked.
// ====
module sas_tdm_model (
    // Start request.
    input wire logic go,
    // Stream pins.
    output logic tdmClk,
    output logic tdmData,
    output logic tdmSync
);
    logic [9:0] v;
    // Each slot carries a value of its own.
    function automatic logic [9:0] slot(int s);
        return 10'h2A5 ^ s[9:0];
    endfunction
    // Bits move on the falling edge so they are steady at the rising edge.
    initial begin
        tdmClk = 1'b0;
        tdmData = 1'b0;
        tdmSync = 1'b0;
        wait (go) #20;
        for (int b = 0; b < 1920; b++) begin
            v = slot(b / 10);
            tdmSync = b == 0;
            tdmData = v[9 - b % 10];
            #400 tdmClk = 1'b1;
            #400 tdmClk = 1'b0;
        end
        tdmSync = 1'b0;
        tdmData = !tdmData;
    end
endmodule
`default_nettype wire

// File: test_sas_embedder_shuffler.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// Bench: register port, video paths, stream and indicators.
// ====
module test_sas_embedder_shuffler;
    import sas_pkg::*;
    localparam logic [31:0] ROUTE = 32'h090B_0D0F;
    localparam int LOSS_CYC = 8;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic coldResetButton = 1'b0;
    logic variantSelectIn = 1'b0;
    logic defaultAudioModeIn = 1'b1;
    logic [SUPPLY_N-1:0] supplyOk = '1;
    logic tdmGo = 1'b0;
    logic ch0On = 1'b1;
    wire tdmClk, tdmData, tdmSync;
    sas_vid_t vidPri [NUM_CH] = '{default: '0};
    sas_vid_t vidRed [NUM_CH] = '{default: '0};
    sas_vid_t vidOut [NUM_CH];
    sas_leds_t leds;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic [31:0] regRdata;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    int cyc = 0;
    int err_count = 0;
    int n_checks = 0;

    sas_embedder_shuffler #(.LOCK_WORDS(4), .LOSS_CYC(LOSS_CYC), .COMMS_HOLD(20)) dut_u (
        .mclk, .reset_n, .coldResetButton, .variantSelectIn, .defaultAudioModeIn,
        .supplyOk, .tdmClk, .tdmData, .tdmSync, .vidPri, .vidRed, .vidOut,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .leds
    );
    sas_tdm_model tdm_u (.go(tdmGo), .tdmClk, .tdmData, .tdmSync);

    // Free-running 10 MHz clock.
    initial forever #50 mclk = ~mclk;

    // Input word n of channel c; data depends only on channel, pair and side.
    function automatic sas_vid_t word(int c, int n);
        sas_vid_t w;
        w.valid = 1'b1;
        w.anc = n[4];
        w.right = n[0];
        w.pair = n[3:1];
        w.rate = c == 11 ? SAS_RATE_3G : c == 10 ? SAS_RATE_OTHER :
            c[0] ? SAS_RATE_SD : SAS_RATE_HD;
        w.data = {c[3:0], n[3:0], 2'b10};
        return w;
    endfunction
    // Expected output; even pairs are routed from pair 7-p, odd ones are free.
    function automatic sas_vid_t expect_w(int c, int n, logic shuf, logic pass);
        sas_vid_t w;
        logic [2:0] s;
        int t;
        w = word(c, n + (c == 1));
        s = 3'd7 - w.pair;
        t = 2 * (c * 8 + s) + w.right;
        if (c > 9) return '0;
        if (w.anc && !w.pair[0]) begin
            w.data = shuf ? {c[3:0], s, w.right, 2'b10} : 10'h2A5 ^ t[9:0];
        end else if (w.anc && !pass) begin
            w.data = '0;
        end
        return w;
    endfunction

    // Video driver; channel 1's redundant feed runs one word ahead.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        for (int c = 0; c < NUM_CH; c++) begin
            vidPri[c] <= (c == 0 && !ch0On) ? sas_vid_t'(0) : word(c, cyc);
            vidRed[c] <= word(c, cyc + 1);
        end
    end
    // A hang is cut short well past the expected run length.
    always @(posedge mclk) begin
        if (cyc == 40000) begin
            err_count++;
            final_report;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus tasks end 1 ns past the edge, so a following call never lands on it.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    task automatic chk_vid(input logic shuf, input logic pass);
        repeat (32) begin
            @(posedge mclk);
            #1;
            foreach (vidOut[c])
                chk(32'(vidOut[c]), 32'(expect_w(c, cyc - 41, shuf, pass)));
        end
        $display("video test done at %0t", $time);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        rdchk(REG_CTRL, CTRL_RESET);
        rdchk(8'h08, READ_UNMAPPED);
        rdchk(REG_ROUTE_LAST, ROUTE_RESET);
        chk(32'(leds.controlComms), 32'h0000_0001);
        wr(REG_CTRL, 32'h0002_0003);
        for (int c = 0; c < NUM_CH; c++) wr(ADDR_W'(REG_ROUTE_BASE + 4 * c), ROUTE);
        rdchk(REG_ROUTE_LAST, ROUTE);
        chk({leds.audioProcCfg, leds.chanLogicCfg, leds.chanLock}, 32'h0000_33FF);
        rdchk(REG_STATUS, 32'h0C00_C3FF);
        $display("register test done at %0t", $time);
        tdmGo <= 1'b1;
        repeat (15400) @(posedge mclk);
        #1;
        rdchk(REG_STATUS, 32'h0C00_D3FF);
        chk_vid(1'b0, 1'b1);
        defaultAudioModeIn <= 1'b0;
        repeat (50) @(posedge mclk);
        chk_vid(1'b0, 1'b0);
        variantSelectIn <= 1'b1;
        repeat (60) @(posedge mclk);
        chk_vid(1'b1, 1'b0);
        defaultAudioModeIn <= 1'b1;
        repeat (60) @(posedge mclk);
        chk_vid(1'b1, 1'b1);
        supplyOk <= 4'b1011;
        ch0On <= 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk({leds.suppliesGood, leds.faultAlarm, leds.controlComms, leds.chanLock},
            32'h0000_23FE);
        supplyOk <= '1;
        ch0On <= 1'b1;
        coldResetButton <= 1'b1;
        repeat (5) @(posedge mclk);
        coldResetButton <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        rdchk(REG_CTRL, CTRL_RESET);
        $display("indicator and reset test done at %0t", $time);
        final_report;
    end
endmodule

// Port checker rides on the design's top module.
bind sas_embedder_shuffler sas_embedder_shuffler_asserts #(.LOSS_CYC(LOSS_CYC)) chk_u (
    .mclk, .reset_n, .coldResetButton, .supplyOk, .regWr, .regRd, .regRdata,
    .vidPri, .vidOut, .leds
);
`default_nettype wire
